//--- tmrf_regs.vh
`ifndef TMRF_REGS_VH
`define TMRF_REGS_VH

// register indices; byte address is four times the index
`define TMRF_IDX_CNT        6'h04
`define TMRF_IDX_SYS_CTRL1  6'h06
`define TMRF_IDX_CH_IRQ_EN  6'h0C
`define TMRF_IDX_SYS_CTRL2  6'h0D
`define TMRF_IDX_CH_FLAGS   6'h0E
`define TMRF_IDX_OVF_FLAGS  6'h0F

// field positions
`define TMRF_CH_LSB         4
`define TMRF_CH_MSB         7
`define TMRF_BIT_OVF_IRQ_EN 7
`define TMRF_BIT_CNT_RST    3
`define TMRF_PRE_MSB        2
`define TMRF_PRE_LSB        0
`define TMRF_BIT_FAST_CLR   4
`define TMRF_BIT_OVF_FLAG   7

// reset values
`define TMRF_RST_CH_EN      4'h0
`define TMRF_RST_PRE        3'h0
`define TMRF_RST_BIT        1'b0

// counter limits
`define TMRF_CNT_ZERO       16'h0000
`define TMRF_CNT_MAX        16'hFFFF
`define TMRF_CNT_STEP       16'h0001
`define TMRF_PRE_ZERO       7'h00
`define TMRF_PRE_STEP       7'h01

`endif

//--- tmrf_core.v
`timescale 1ns/100ps
`include "tmrf_regs.vh"

// Function
// - each channel has an irq enable in bits 7..4 gating its event flag
// - overflow flag raises irq only while overflow irq enable bit 7 is set
// - counter reset enable bit 3 lets a channel 7 match zero the counter
// - reset enabled with channel 7 compare zero holds the counter at zero
// - reset enabled with compare all ones gives no overflow flag
// - reset period is compare times prescale width plus one bus clock
// - prescale select bits 2..0 divide the bus clock by two to the field
// - new prescale applies only when all prescale stages are zero
// - channel event flags in bits 7..4 set on capture or compare events
// - writing one clears a channel flag, writing zero leaves it
// - with fast clear, capture value read or compare value write clears channel flag
// - overflow flag bit 7 sets when the 16-bit counter wraps to zero
// - writing one to the overflow flag clears it
// - with fast clear, any counter access clears the overflow flag
// - enable and control registers read-write, flags readable, any time
// - fast clear is bit 4 of system control 1, else write-one only
module tmrf_core (
    // clock and reset
    input  wire        mclk,
    input  wire        reset,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // channel side, bit 0 is channel 4
    input  wire [3:0]  chan_event,
    input  wire [3:0]  chan_is_capture,
    input  wire [3:0]  chan_value_read,
    input  wire [3:0]  chan_value_write,
    input  wire [15:0] channel7_compare_value,
    // timer outputs
    output wire [15:0] free_running_counter,
    output wire        irq
);

    // software registers
    reg  [3:0]  ch_irq_en_ff;
    reg         ovf_irq_en_ff;
    reg         cnt_rst_ff;
    reg  [2:0]  pre_sel_ff;
    reg         fast_clr_ff;
    reg  [3:0]  ch_flag_ff;
    reg         ovf_flag_ff;

    // counter state
    reg  [2:0]  pre_act_ff;
    reg  [6:0]  pre_cnt_ff;
    reg  [15:0] cnt_ff;
    reg         hit7_ff;

    // bus outputs
    reg  [31:0] prdata_ff;
    reg         pready_ff;
    reg         pslverr_ff;
    reg         irq_ff;

    // next values
    reg  [2:0]  nxt_pre_act;
    reg  [6:0]  nxt_pre_cnt;
    reg  [15:0] nxt_cnt;
    reg         nxt_hit7;
    reg         ovf_event;
    reg  [31:0] nxt_rdata;
    reg         nxt_mapped;
    wire [3:0]  nxt_ch_flag;
    wire        nxt_ovf_flag;
    wire        nxt_irq;

    function addr_is;
        input [7:0] addr;
        input [5:0] idx;
        begin
            addr_is = (addr == {idx, 2'b00});
        end
    endfunction

    function [6:0] div_mask;
        input [2:0] sel;
        begin
            div_mask = (`TMRF_PRE_STEP << sel) - `TMRF_PRE_STEP;
        end
    endfunction

    // apb phases: pready_ff is high only in the one access cycle, so
    // access marks the edge at which writes land and read data is taken
    wire setup_ph = psel & ~penable;
    wire access   = psel & penable & pready_ff;
    wire wr_acc   = access & pwrite;
    wire rd_acc   = access & ~pwrite;

    wire sel_cnt  = addr_is(paddr, `TMRF_IDX_CNT);
    wire sel_sc1  = addr_is(paddr, `TMRF_IDX_SYS_CTRL1);
    wire sel_ien  = addr_is(paddr, `TMRF_IDX_CH_IRQ_EN);
    wire sel_sc2  = addr_is(paddr, `TMRF_IDX_SYS_CTRL2);
    wire sel_flg1 = addr_is(paddr, `TMRF_IDX_CH_FLAGS);
    wire sel_flg2 = addr_is(paddr, `TMRF_IDX_OVF_FLAGS);

    // per-register write strobes and the counter access strobe, taken at the access edge
    wire wr_sc1   = wr_acc & sel_sc1;
    wire wr_ien   = wr_acc & sel_ien;
    wire wr_sc2   = wr_acc & sel_sc2;
    wire wr_flg1  = wr_acc & sel_flg1;
    wire wr_flg2  = wr_acc & sel_flg2;
    wire acc_cnt  = access & sel_cnt;

    // a tick ends each prescale period; /1 ticks every cycle
    wire [6:0] pre_mask = div_mask(pre_act_ff);
    wire       tick     = ((pre_cnt_ff & pre_mask) == pre_mask);

    // the active divider only reloads when every stage is zero, so a
    // new selection never cuts a running period short
    always @* begin
        nxt_pre_act = pre_act_ff;
        if (pre_cnt_ff == `TMRF_PRE_ZERO) begin
            nxt_pre_act = pre_sel_ff;
        end
    end

    // match on channel 7 is registered one bus clock ahead of the counter reset
    wire [15:0] cnt_inc    = cnt_ff + `TMRF_CNT_STEP;
    wire        cnt_at_max = (cnt_ff == `TMRF_CNT_MAX);
    wire        cmp_zero   = (channel7_compare_value == `TMRF_CNT_ZERO);
    // compare zero pins the counter while the prescaler keeps running
    wire        hold_zero  = cnt_rst_ff & cmp_zero;
    wire        cmp_match  = cnt_rst_ff &
                             (cnt_inc == channel7_compare_value);

    always @* begin
        nxt_pre_cnt = pre_cnt_ff + `TMRF_PRE_STEP;
        nxt_cnt     = cnt_ff;
        nxt_hit7    = 1'b0;
        ovf_event   = 1'b0;
        if (hold_zero) begin
            nxt_cnt = `TMRF_CNT_ZERO;
        end else if (hit7_ff) begin
            // reset one bus clock after the match, restart prescaler so
            // the period is compare times width plus that one clock
            nxt_cnt     = `TMRF_CNT_ZERO;
            nxt_pre_cnt = `TMRF_PRE_ZERO;
        end else if (tick) begin
            nxt_cnt = cnt_inc;
            if (cnt_at_max) begin
                ovf_event = 1'b1;
            end
            if (cmp_match) begin
                nxt_hit7 = 1'b1;
            end
        end
    end
    // with compare at all ones the wrap goes via the match reset,
    // which never raises ovf_event

    // channel flags: set wins over every clear source
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_chan
            wire wr_clr   = wr_flg1 &
                            pwdata[`TMRF_CH_LSB + g];
            wire fast_clr = fast_clr_ff &
                            ((chan_value_read[g] & chan_is_capture[g]) |
                             (chan_value_write[g] &
                              ~chan_is_capture[g]));
            assign nxt_ch_flag[g] = chan_event[g] |
                                    (ch_flag_ff[g] &
                                     ~(wr_clr | fast_clr));
        end
    endgenerate

    wire ovf_wr_clr   = wr_flg2 &
                        pwdata[`TMRF_BIT_OVF_FLAG];
    // a hazard for software: any stray counter access drops a pending
    // overflow while fast clear is on
    wire ovf_fast_clr = fast_clr_ff & acc_cnt;
    assign nxt_ovf_flag = ovf_event |
                          (ovf_flag_ff &
                           ~(ovf_wr_clr | ovf_fast_clr));

    // interrupt requests, one per channel plus overflow
    wire [3:0] ch_irq_req;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_irq
            assign ch_irq_req[g] = nxt_ch_flag[g] & ch_irq_en_ff[g];
        end
    endgenerate
    wire ovf_irq_req = nxt_ovf_flag & ovf_irq_en_ff;
    assign nxt_irq = (|ch_irq_req) | ovf_irq_req;

    // read mux, unused bits zero
    always @* begin
        nxt_rdata  = 32'h00000000;
        nxt_mapped = 1'b1;
        if (sel_cnt) begin
            nxt_rdata[15:0] = cnt_ff;
        end else if (sel_sc1) begin
            nxt_rdata[`TMRF_BIT_FAST_CLR] = fast_clr_ff;
        end else if (sel_ien) begin
            nxt_rdata[`TMRF_CH_MSB:`TMRF_CH_LSB] = ch_irq_en_ff;
        end else if (sel_sc2) begin
            nxt_rdata[`TMRF_BIT_OVF_IRQ_EN] = ovf_irq_en_ff;
            nxt_rdata[`TMRF_BIT_CNT_RST]    = cnt_rst_ff;
            nxt_rdata[`TMRF_PRE_MSB:`TMRF_PRE_LSB] = pre_sel_ff;
        end else if (sel_flg1) begin
            nxt_rdata[`TMRF_CH_MSB:`TMRF_CH_LSB] = ch_flag_ff;
        end else if (sel_flg2) begin
            nxt_rdata[`TMRF_BIT_OVF_FLAG] = ovf_flag_ff;
        end else begin
            nxt_mapped = 1'b0;
        end
    end
    // only defined bits are stored, so the rest ignore writes

    // channel interrupt enables
    always @(posedge mclk) begin
        if (reset) begin
            ch_irq_en_ff <= `TMRF_RST_CH_EN;
        end else if (wr_ien) begin
            ch_irq_en_ff <= pwdata[`TMRF_CH_MSB:`TMRF_CH_LSB];
        end
    end

    // system control 2: overflow enable, match reset, prescale
    always @(posedge mclk) begin
        if (reset) begin
            ovf_irq_en_ff <= `TMRF_RST_BIT;
            cnt_rst_ff    <= `TMRF_RST_BIT;
            pre_sel_ff    <= `TMRF_RST_PRE;
        end else if (wr_sc2) begin
            ovf_irq_en_ff <= pwdata[`TMRF_BIT_OVF_IRQ_EN];
            cnt_rst_ff    <= pwdata[`TMRF_BIT_CNT_RST];
            pre_sel_ff    <= pwdata[`TMRF_PRE_MSB:`TMRF_PRE_LSB];
        end
    end

    // system control 1: fast flag clear
    always @(posedge mclk) begin
        if (reset) begin
            fast_clr_ff <= `TMRF_RST_BIT;
        end else if (wr_sc1) begin
            fast_clr_ff <= pwdata[`TMRF_BIT_FAST_CLR];
        end
    end

    // channel event flags
    always @(posedge mclk) begin
        if (reset) begin
            ch_flag_ff <= `TMRF_RST_CH_EN;
        end else begin
            ch_flag_ff <= nxt_ch_flag;
        end
    end

    // overflow flag
    always @(posedge mclk) begin
        if (reset) begin
            ovf_flag_ff <= `TMRF_RST_BIT;
        end else begin
            ovf_flag_ff <= nxt_ovf_flag;
        end
    end

    // irq follows the next flag values so it rises with the flag
    always @(posedge mclk) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // prescaler
    always @(posedge mclk) begin
        if (reset) begin
            pre_act_ff <= `TMRF_RST_PRE;
            pre_cnt_ff <= `TMRF_PRE_ZERO;
        end else begin
            pre_act_ff <= nxt_pre_act;
            pre_cnt_ff <= nxt_pre_cnt;
        end
    end

    // free-running counter and pending match reset
    always @(posedge mclk) begin
        if (reset) begin
            cnt_ff  <= `TMRF_CNT_ZERO;
            hit7_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            hit7_ff <= nxt_hit7;
        end
    end

    // apb answer: one access cycle, never a wait state
    always @(posedge mclk) begin
        if (reset) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup_ph;
            pslverr_ff <= setup_ph & ~nxt_mapped;
        end
    end

    // read data is a snapshot taken at setup, dropped after the access
    always @(posedge mclk) begin
        if (reset) begin
            prdata_ff <= 32'h00000000;
        end else if (setup_ph) begin
            prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
        end else if (rd_acc) begin
            prdata_ff <= 32'h00000000;
        end
    end

    assign prdata               = prdata_ff;
    assign pready               = pready_ff;
    assign pslverr              = pslverr_ff;
    assign irq                  = irq_ff;
    assign free_running_counter = cnt_ff;

endmodule // tmrf_core

//--- tmrf_core_properties.sv
`timescale 1ns/100ps
module tmrf_core_chk (
    // clock and reset
    input wire        mclk,
    input wire        reset,
    // apb slave
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // channel side
    input wire [3:0]  chan_event,
    input wire [3:0]  chan_is_capture,
    input wire [3:0]  chan_value_read,
    input wire [3:0]  chan_value_write,
    input wire [15:0] channel7_compare_value,
    // timer outputs
    input wire [15:0] free_running_counter,
    input wire        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read_ack;
        pready && !pwrite;
    endsequence
    chk_ready_pulse: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_unmapped: assert property ((s_setup and paddr == 8'h20)
        |=> pslverr)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property ((s_setup and paddr == 8'h38)
        |=> !pslverr)
        else $error("mapped access refused");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    chk_rdata_high: assert property (s_read_ack |->
        prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    chk_cnt_step: assert property (!$stable(free_running_counter) |->
        free_running_counter == $past(free_running_counter) + 16'h1 ||
        free_running_counter == 16'h0)
        else $error("counter jumped");
    // irq may only rise after an event, a wrap or a register write
    chk_irq_cause: assert property ($rose(irq) |->
        $past(|chan_event) ||
        $past(free_running_counter == 16'hFFFF) ||
        $past(psel && penable && pwrite, 2) ||
        $past(psel && penable && pwrite))
        else $error("irq rose without cause");
endmodule // tmrf_core_chk

bind tmrf_core tmrf_core_chk i_tmrf_core_chk (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_event(chan_event), .chan_is_capture(chan_is_capture),
    .chan_value_read(chan_value_read), .chan_value_write(chan_value_write),
    .channel7_compare_value(channel7_compare_value),
    .free_running_counter(free_running_counter), .irq(irq));

//--- test_timer_irq_prescale_flags.sv
`timescale 1ns/100ps
module test_timer_irq_prescale_flags;
    reg         mclk = 1'h0, reset = 1'h1, re;
    reg         psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, rv;
    reg  [3:0]  ev = 4'h0, cap = 4'h0, vrd = 4'h0, vwr = 4'h0;
    reg  [15:0] cmp = 16'h0;
    wire [31:0] prdata;
    wire [15:0] cnt;
    wire        pready, pslverr, irq;
    integer     fail_count = 0, n_checks = 0, i, n;
    always #25 mclk = ~mclk;
    tmrf_core i_tmrf_core (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_event(ev), .chan_is_capture(cap), .chan_value_read(vrd),
        .chan_value_write(vwr), .channel7_compare_value(cmp),
        .free_running_counter(cnt), .irq(irq));
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        n_checks = n_checks + 1;
        if (s !== e) begin
            fail_count = fail_count + 1;
            $display("ERROR t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // a spent bound is a hang: count it and close the run
    task bound(input integer lim);
        if (n >= lim) begin
            fail_count = fail_count + 1;
            test_done;
        end
    endtask
    task xfer(input w, input [7:0] a, input [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        @(posedge mclk);
        while (pready !== 1'h1 && n < 20) begin
            @(posedge mclk);
            n = n + 1;
        end
        bound(20);
        rv = prdata;
        re = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk(rv, e);
    endtask
    task pulse(input [11:0] p);
        @(posedge mclk);
        {ev, vrd, vwr} <= p;
        @(posedge mclk);
        {ev, vrd, vwr} <= 12'h000;
    endtask
    task wt(input [15:0] v);
        n = 0;
        @(negedge mclk);
        while (cnt !== v && n < 70000) begin
            @(negedge mclk);
            n = n + 1;
        end
        bound(70000);
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'h0;
        for (i = 0; i < 5; i = i + 1)
            rd(i == 0 ? 8'h18 : 8'h2C + 4 * i, 32'h0);
        xfer(1'h1, 8'h30, 32'hFFFFFFFF);
        rd(8'h30, 32'hF0);
        xfer(1'h1, 8'h34, 32'hFFFFFFFF);
        rd(8'h34, 32'h8F);
        xfer(1'h1, 8'h20, 32'hFF);
        chk(re, 1'h1);
        $display("registers done");
        xfer(1'h1, 8'h34, 32'h0);
        pulse({4'hF, 8'h00});
        rd(8'h38, 32'hF0);
        chk(irq, 1'h1);
        xfer(1'h1, 8'h38, 32'h10);
        rd(8'h38, 32'hE0);
        xfer(1'h1, 8'h30, 32'h0);
        repeat (2) @(negedge mclk);
        chk(irq, 1'h0);
        xfer(1'h1, 8'h18, 32'hFF);
        rd(8'h18, 32'h10);
        cap <= 4'hA;
        pulse({4'h0, 4'h2, 4'h0});
        rd(8'h38, 32'hC0);
        pulse({8'h00, 4'h8});
        rd(8'h38, 32'hC0);
        pulse({8'h00, 4'h4});
        rd(8'h38, 32'h80);
        xfer(1'h1, 8'h18, 32'h0);
        $display("flags done");
        // compare still zero: park the counter so no wrap is needed
        xfer(1'h1, 8'h34, 32'h08);
        cmp <= 16'h0003;
        for (i = 0; i < 3; i = i + 1) begin
            xfer(1'h1, 8'h34, 32'h08 + i);
            repeat (2) begin
                wt(16'h0003);
                @(posedge mclk);
            end
            wt(16'h0003);
            chk(n + 1, 3 * (1 << i) + 1);
        end
        cmp <= 16'h0000;
        repeat (300) @(negedge mclk);
        repeat (20) begin
            @(negedge mclk);
            chk(cnt, 16'h0);
        end
        $display("counter done");
        xfer(1'h1, 8'h34, 32'h80);
        wt(16'hFFFF);
        rd(8'h3C, 32'h80);
        chk(irq, 1'h1);
        xfer(1'h1, 8'h34, 32'h0);
        repeat (2) @(negedge mclk);
        chk(irq, 1'h0);
        xfer(1'h1, 8'h3C, 32'h80);
        rd(8'h3C, 32'h0);
        $display("overflow done");
        test_done;
    end
endmodule // test_timer_irq_prescale_flags
